// ==== shared/enc_link_pkg.sv ====
// shared constants, state codes and the frame checksum for the position link
`default_nettype none
package enc_link_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned MCLK_HZ = 10_000_000;
  localparam int unsigned MCLK_NS = 100;
  // idle time that ends a frame on the slave: monoflop and frame timeout
  localparam int unsigned TIMEOUT_NS = 25_000;
  localparam int unsigned TIMEOUT_CYC = (TIMEOUT_NS + MCLK_NS - 1) / MCLK_NS;
  // least pause the master keeps after its last edge
  localparam int unsigned PAUSE_NS = 26_000;
  // slave sees our edges a few cycles late; stay strictly above the pause
  localparam int unsigned SLAVE_LAG_CYC = 4;
  localparam int unsigned PAUSE_CYC = (PAUSE_NS + MCLK_NS - 1) / MCLK_NS + SLAVE_LAG_CYC;
  localparam int unsigned TIMER_W = 10;
  // position refresh rate
  localparam int unsigned UPDATE_HZ_DEFAULT = 35_000;
  localparam int unsigned UPDATE_HZ_MIN = 1_000;
  localparam int unsigned UPDATE_HZ_MAX = 375_000;
  localparam int unsigned REFRESH_W = 16;
  // link clock: half period in mclk cycles
  localparam int unsigned LINK_HZ_MIN = 100_000;
  localparam int unsigned HALF_DIV_DEFAULT = 5;
  localparam int unsigned HALF_DIV_MIN = 4;
  localparam int unsigned HALF_DIV_MAX = MCLK_HZ / (2 * LINK_HZ_MIN);

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int unsigned RES_DEFAULT = 20;
  localparam int unsigned RES_MIN = 17;
  localparam int unsigned RES_MAX = 20;
  localparam int unsigned FRAME_EXTRA = 11; // ack, start, zero, error, warning, 6 crc
  localparam int unsigned ERR_POS = 7;
  localparam int unsigned WARN_POS = 6;
  localparam int unsigned CRC_W = 6;
  localparam logic [5:0] CRC_POLY = 6'h03; // x^6 + x^1 + x^0
  localparam logic [2:0] HEAD_BITS = 3'h2; // ack 0, start 1, zero 0

  // ----------------------------------------------------------------
  // state codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DEV_IDLE  = 3'h1,
    DEV_SHIFT = 3'h2,
    DEV_HOLD  = 3'h4
  } dev_state_e;

  typedef enum logic [2:0] {
    HOST_IDLE  = 3'h1,
    HOST_CLOCK = 3'h2,
    HOST_WAIT  = 3'h4
  } host_state_e;

  // crc over the low len bits of d, msb first, zero seed
  function automatic logic [5:0] crc6(input logic [31:0] d, input int unsigned len);
    logic [5:0] c;
    logic       fb;
    c = 6'h00;
    for (int i = 31; i >= 0; i--)
    begin
      if (i < len)
      begin
        fb = c[5] ^ d[i];
        c = {c[4:0], 1'b0};
        if (fb)
        begin
          c = c ^ CRC_POLY;
        end
      end
    end
    return c;
  endfunction

endpackage
`default_nettype wire

// ==== shared/enc_link_if.sv ====
// link wires between position master and encoder slave
`timescale 1ns/100ps
`default_nettype none
interface enc_link_if;
  // each wire stands for one differential pair; in setup mode the clock
  // pair carries the master's serial transmit and the data pair the reply
  logic sclk;
  logic sdata;

  modport device (input sclk, output sdata);
  modport host (output sclk, input sdata);
endinterface
`default_nettype wire

// ==== logic/encoder_serial_slave.sv ====
// encoder end: serves latched position frames on the master's clock
// What this block does
// - powers up serving position frames, no setup
// - setup mode reuses clock and data wires
// - position refreshed at 35 kHz, up to 375
// - master clocks, slave shifts in step, point-to-point
// - serial frame adds status bit, 1 on fault
// - master spaces requests over n*T plus 26us
// - frame flows slave to master on master clock
// - frame opens with one low ack cycle
// - then start bit 1, then a 0
// - then position bits, resolution 17 to 20
// - error at 7, warning at 6 always 1
// - error bit 1 normal, 0 fault, 1 untested
// - inverted six-bit crc, msb first, ends frame
// - start and zero bits left out of crc
// - 25us timeout between frames, no early request
`timescale 1ns/100ps
`default_nettype none
module encoder_serial_slave
  import enc_link_pkg::*;
#(
  parameter int unsigned RES       = RES_DEFAULT,
  parameter bit          HAS_BIT   = 1'b1,
  parameter int unsigned UPDATE_HZ = UPDATE_HZ_DEFAULT
)
(
  input  wire logic           mclk,
  input  wire logic           rst_n,
  enc_link_if.device          link,
  input  wire logic           bissMode,
  input  wire logic           setupMode,
  input  wire logic           setupTx,
  output logic                setupRx,
  input  wire logic [RES-1:0] angle,
  input  wire logic           fault,
  output logic                busy
);

  // ----------------------------------------------------------------
  // sizes and checks
  // ----------------------------------------------------------------
  localparam int unsigned FW = RES + FRAME_EXTRA;
  localparam int unsigned SSI_LEN = RES + (HAS_BIT ? 1 : 0);
  localparam int unsigned UPDATE_CYC = MCLK_HZ / UPDATE_HZ;

  if (RES < RES_MIN || RES > RES_MAX)
  begin : g_res_check
    $error("resolution out of range");
  end
  if (UPDATE_HZ < UPDATE_HZ_MIN || UPDATE_HZ > UPDATE_HZ_MAX)
  begin : g_rate_check
    $error("refresh rate out of range");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    dev_state_e           st;
    logic                 clkMeta;
    logic                 clkSync;
    logic                 clkPrev;
    logic [RES-1:0]       pos;
    logic [REFRESH_W-1:0] refreshCnt;
    logic [FW-1:0]        shift;
    logic [5:0]           bitsLeft;
    logic [TIMER_W-1:0]   timer;
    logic                 data;
    logic                 rx;
  } state_s;

  localparam state_s RST_VAL = '{
    st:      DEV_IDLE,
    clkMeta: 1'b1,
    clkSync: 1'b1,
    clkPrev: 1'b1,
    data:    1'b1,
    rx:      1'b1,
    default: '0
  };

  state_s stateReg;
  state_s stateNext;

  logic          fall;
  logic          rise;
  logic          errBit;
  logic          statBit;
  logic [5:0]    crcInv;
  logic [FW-1:0] bissFrame;
  logic [FW-1:0] ssiFrame;

  // ----------------------------------------------------------------
  // edges of the sampled link clock and the two frame images
  // ----------------------------------------------------------------
  assign fall = stateReg.clkPrev & ~stateReg.clkSync;
  assign rise = ~stateReg.clkPrev & stateReg.clkSync;

  // status polarity differs between the two protocols
  assign statBit = HAS_BIT ? fault : 1'b0;
  assign errBit = HAS_BIT ? ~fault : 1'b1;

  // crc covers position, error, warning only
  assign crcInv = ~crc6(32'({stateReg.pos, errBit, 1'b1}), RES + 2);

  // ack, start, zero, position, error, warning, crc
  assign bissFrame = {HEAD_BITS, stateReg.pos,
                      errBit, 1'b1, crcInv};

  // position msb first, then status bit when fitted, left aligned
  assign ssiFrame = {stateReg.pos, statBit, 10'h000};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    stateNext = stateReg;

    // two-stage sampling of the master clock, then edge history
    stateNext.clkMeta = link.sclk;
    stateNext.clkSync = stateReg.clkMeta;
    stateNext.clkPrev = stateReg.clkSync;
    stateNext.rx = stateReg.clkSync;

    // periodic refresh of the internal position
    if (stateReg.refreshCnt == REFRESH_W'(UPDATE_CYC - 1))
    begin
      stateNext.refreshCnt = '0;
      stateNext.pos = angle;
    end
    else
    begin
      stateNext.refreshCnt = stateReg.refreshCnt + 1'b1;
    end

    case (stateReg.st)
      DEV_IDLE:
      begin
        // data idles high; in setup mode it carries the service reply
        stateNext.data = setupMode ? setupTx : 1'b1;
        if (!setupMode && fall)
        begin
          // first falling edge takes the request and freezes the frame
          stateNext.shift = bissMode ? bissFrame : ssiFrame;
          stateNext.bitsLeft = bissMode ? 6'(FW) : 6'(SSI_LEN);
          stateNext.timer = '0;
          stateNext.st = DEV_SHIFT;
        end
      end
      DEV_SHIFT:
      begin
        // one bit per rising edge, msb first
        if (rise)
        begin
          stateNext.data = stateReg.shift[FW-1];
          stateNext.shift = {stateReg.shift[FW-2:0], 1'b0};
          stateNext.bitsLeft = stateReg.bitsLeft - 1'b1;
          if (stateReg.bitsLeft == 6'h01)
          begin
            stateNext.st = DEV_HOLD;
          end
        end
      end
      DEV_HOLD:
      begin
        // frame done: line low until the idle time runs out
        if (rise)
        begin
          stateNext.data = 1'b0;
        end
      end
      default:
      begin
        stateNext = RST_VAL;
      end
    endcase

    // any edge retriggers the idle timer; expiry ends the frame
    if (stateReg.st != DEV_IDLE)
    begin
      if (rise || fall)
      begin
        stateNext.timer = '0;
      end
      else if (stateReg.timer == TIMER_W'(TIMEOUT_CYC - 1))
      begin
        stateNext.timer = '0;
        stateNext.data = 1'b1;
        stateNext.st = DEV_IDLE;
      end
      else
      begin
        stateNext.timer = stateReg.timer + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateReg <= RST_VAL;
    end
    else
    begin
      stateReg <= stateNext;
    end
  end

  // outputs
  assign link.sdata = stateReg.data;
  assign setupRx = stateReg.rx;
  assign busy = (stateReg.st != DEV_IDLE);

endmodule
`default_nettype wire

// ==== logic/encoder_serial_master.sv ====
// controller end: clocks position frames out of the encoder and checks them
`timescale 1ns/100ps
`default_nettype none
module encoder_serial_master
  import enc_link_pkg::*;
#(
  parameter int unsigned RES      = RES_DEFAULT,
  parameter bit          HAS_BIT  = 1'b1,
  parameter int unsigned HALF_DIV = HALF_DIV_DEFAULT
)
(
  input  wire logic           mclk,
  input  wire logic           rst_n,
  enc_link_if.host            link,
  input  wire logic           bissMode,
  input  wire logic           setupMode,
  input  wire logic           setupTx,
  output logic                setupRx,
  input  wire logic           start,
  output logic                ready,
  output logic [RES-1:0]      position,
  output logic                statusOk,
  output logic                warnBit,
  output logic                crcOk,
  output logic                frameOk,
  output logic                done
);

  // ----------------------------------------------------------------
  // sizes and checks
  // ----------------------------------------------------------------
  localparam int unsigned FW = RES + FRAME_EXTRA;
  localparam int unsigned SSI_LEN = RES + (HAS_BIT ? 1 : 0);

  if (RES < RES_MIN || RES > RES_MAX)
  begin : g_res_check
    $error("resolution out of range");
  end
  if (HALF_DIV < HALF_DIV_MIN || HALF_DIV > HALF_DIV_MAX)
  begin : g_div_check
    $error("link clock divider out of range");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    host_state_e        st;
    logic               dMeta;
    logic               dSync;
    logic               biss;
    logic [5:0]         halfCnt;
    logic [5:0]         riseCnt;
    logic               sclk;
    logic [TIMER_W-1:0] timer;
    logic [FW-1:0]      rx;
    logic [RES-1:0]     pos;
    logic               statOk;
    logic               warn;
    logic               crcGood;
    logic               frmGood;
    logic               done;
  } state_s;

  localparam state_s RST_VAL = '{
    st:      HOST_IDLE,
    dMeta:   1'b1,
    dSync:   1'b1,
    sclk:    1'b1,
    default: '0
  };

  state_s     stateReg;
  state_s     stateNext;
  logic [5:0] nBits;
  logic       crcMatch;

  // frame length in bits for the active protocol
  assign nBits = stateReg.biss ? 6'(FW) : 6'(SSI_LEN);

  // received crc is inverted; start and zero bits are outside it
  assign crcMatch = (~stateReg.rx[5:0]) ==
                    crc6(32'(stateReg.rx[FW-4:6]), RES + 2);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    stateNext = stateReg;
    stateNext.dMeta = link.sdata;
    stateNext.dSync = stateReg.dMeta;
    stateNext.done = 1'b0;

    case (stateReg.st)
      HOST_IDLE:
      begin
        // clock idles high; in setup mode it carries our service transmit
        stateNext.sclk = setupMode ? setupTx : 1'b1;
        if (start && !setupMode)
        begin
          stateNext.biss = bissMode;
          stateNext.sclk = 1'b0;
          stateNext.halfCnt = '0;
          stateNext.riseCnt = '0;
          stateNext.st = HOST_CLOCK;
        end
      end
      HOST_CLOCK:
      begin
        // divider: one toggle per half period, frame length plus one rises
        if (stateReg.halfCnt == 6'(HALF_DIV - 1))
        begin
          stateNext.halfCnt = '0;
          stateNext.sclk = ~stateReg.sclk;
          if (!stateReg.sclk)
          begin
            // each rise after the first takes the bit shifted on the last one
            if (stateReg.riseCnt != 6'h00)
            begin
              stateNext.rx = {stateReg.rx[FW-2:0], stateReg.dSync};
            end
            stateNext.riseCnt = stateReg.riseCnt + 1'b1;
            if (stateReg.riseCnt == nBits)
            begin
              stateNext.timer = '0;
              stateNext.st = HOST_WAIT;
            end
          end
        end
        else
        begin
          stateNext.halfCnt = stateReg.halfCnt + 1'b1;
        end
      end
      HOST_WAIT:
      begin
        // decode once, then hold off the next request
        if (stateReg.timer == '0)
        begin
          stateNext.done = 1'b1;
          if (stateReg.biss)
          begin
            stateNext.pos = stateReg.rx[FW-4 -: RES];
            stateNext.statOk = stateReg.rx[ERR_POS];
            stateNext.warn = stateReg.rx[WARN_POS];
            stateNext.crcGood = crcMatch;
            stateNext.frmGood = crcMatch && (stateReg.rx[FW-1 -: 3] == HEAD_BITS);
          end
          else
          begin
            stateNext.pos = stateReg.rx[SSI_LEN-1 -: RES];
            stateNext.statOk = HAS_BIT ? ~stateReg.rx[0] : 1'b1;
            stateNext.warn = 1'b0;
            stateNext.crcGood = 1'b1;
            stateNext.frmGood = 1'b1;
          end
        end
        // pause covers both the frame timeout and the request spacing
        if (stateReg.timer == TIMER_W'(PAUSE_CYC - 1))
        begin
          stateNext.st = HOST_IDLE;
        end
        else
        begin
          stateNext.timer = stateReg.timer + 1'b1;
        end
      end
      default:
      begin
        stateNext = RST_VAL;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateReg <= RST_VAL;
    end
    else
    begin
      stateReg <= stateNext;
    end
  end

  // outputs
  assign link.sclk = stateReg.sclk;
  assign setupRx = stateReg.dSync;
  assign ready = (stateReg.st == HOST_IDLE) && !setupMode;
  assign position = stateReg.pos;
  assign statusOk = stateReg.statOk;
  assign warnBit = stateReg.warn;
  assign crcOk = stateReg.crcGood;
  assign frameOk = stateReg.frmGood;
  assign done = stateReg.done;

endmodule
`default_nettype wire

// ==== verification/enc_link_asserts.sv ====
// wire-level checker for the position link between master and encoder ends
`timescale 1ns/100ps
`default_nettype none
module enc_link_asserts
#(
  parameter int unsigned RES = 20
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic bissMode,
  input wire logic setupMode,
  input wire logic fault
);
  logic       sclkQ;
  logic [9:0] idleCnt;
  logic [5:0] riseCnt;
  logic       riseNow;
  logic       fallNow;

  // ----------------------------------------------------------------
  // link clock edge tracking
  // ----------------------------------------------------------------
  // edges seen at mclk; idleCnt saturates so a long pause reads as idle
  assign riseNow = sclk && !sclkQ;
  assign fallNow = !sclk && sclkQ;

  // cycles since last edge, rises since frame start
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclkQ   <= 1'b1;
      idleCnt <= 10'h3FF;
      riseCnt <= 6'h00;
    end
    else
    begin
      sclkQ   <= sclk;
      idleCnt <= (sclk != sclkQ) ? 10'h000 : (idleCnt == 10'h3FF) ? idleCnt : idleCnt + 10'h001;
      if (setupMode || (fallNow && idleCnt >= 10'h008))
      begin
        riseCnt <= 6'h00;
      end
      else if (riseNow)
      begin
        riseCnt <= riseCnt + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || setupMode);

  // ack, start and zero slots on three successive rises
  sequence head_seq;
    !sdata ##8 sdata ##8 !sdata;
  endsequence

  // one low half period of the divided link clock
  sequence low_span_seq;
    (!sclk) [*4] ##1 sclk;
  endsequence

  idle_reset_a: assert property ($rose(rst_n) |-> sclk && sdata)
    else $error("link not idle after reset");
  data_release_a: assert property (idleCnt >= 10'h104 |-> sdata)
    else $error("data not released after idle time");
  request_gap_a: assert property (fallNow && idleCnt >= 10'h008 |-> idleCnt >= 10'h103)
    else $error("frame started before the pause ran out");
  clock_half_a: assert property (fallNow |-> low_span_seq)
    else $error("link clock low span wrong");
  frame_head_a: assert property (riseNow && bissMode && riseCnt == 6'h01 |-> head_seq)
    else $error("frame head slots wrong");
  warn_bit_a: assert property (riseNow && bissMode && riseCnt == 6'(RES + 5) |-> sdata)
    else $error("warning slot not high");
  biss_error_a: assert property (riseNow && bissMode && riseCnt == 6'(RES + 4)
    |-> sdata == !fault)
    else $error("error slot polarity wrong");
  ssi_status_a: assert property (riseNow && !bissMode && riseCnt == 6'(RES + 1)
    |-> sdata == fault)
    else $error("status bit polarity wrong");
  frame_len_a: assert property (idleCnt == 10'h014 && sclk
    |-> riseCnt == (bissMode ? 6'(RES + 12) : 6'(RES + 2)))
    else $error("rise count of frame wrong");
  // a new request only after a pause longer than 26 us past the last edge
  request_space_a: assert property (fallNow && idleCnt >= 10'h008
    |-> idleCnt >= 10'h104)
    else $error("request spacing too short");
endmodule
`default_nettype wire

// ==== verification/test_encoder_position_serial_slave.sv ====
// self-checking bench joining the master end and the encoder end
`timescale 1ns/100ps
`default_nettype none
module test_encoder_position_serial_slave;
  import enc_link_pkg::*;
  localparam int unsigned RES = 20;
  logic           mclk;
  logic           rst_n;
  logic           bissMode;
  logic           setupMode;
  logic           sTx;
  logic           mTx;
  logic           sRx;
  logic           mRx;
  logic [RES-1:0] angle;
  logic           fault;
  logic           busy;
  logic           start;
  logic           ready;
  logic [RES-1:0] position;
  logic           statusOk;
  logic           warnBit;
  logic           crcOk;
  logic           frameOk;
  logic           done;
  logic [63:0]    cap;
  int             capN;
  int             fail_count;
  int             n_compared;
  logic [RES-1:0] tab [3];

  enc_link_if link ();

  // ----------------------------------------------------------------
  // both ends and the wire checker
  // ----------------------------------------------------------------
  encoder_serial_slave #(.RES(RES), .HAS_BIT(1'b1), .UPDATE_HZ(375_000)) i_encoder_serial_slave (
    .mclk(mclk), .rst_n(rst_n), .link(link), .bissMode(bissMode), .setupMode(setupMode),
    .setupTx(sTx), .setupRx(sRx), .angle(angle), .fault(fault), .busy(busy));
  encoder_serial_master #(.RES(RES), .HAS_BIT(1'b1), .HALF_DIV(4)) i_encoder_serial_master (
    .mclk(mclk), .rst_n(rst_n), .link(link), .bissMode(bissMode), .setupMode(setupMode),
    .setupTx(mTx), .setupRx(mRx), .start(start), .ready(ready), .position(position),
    .statusOk(statusOk), .warnBit(warnBit), .crcOk(crcOk), .frameOk(frameOk), .done(done));
  enc_link_asserts #(.RES(RES)) i_enc_link_asserts (
    .mclk(mclk), .rst_n(rst_n), .sclk(link.sclk), .sdata(link.sdata), .bissMode(bissMode),
    .setupMode(setupMode), .fault(fault));

  // clock and watchdog
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial
  begin
    #3_000_000;
    fail_count++;
    end_sim;
  end

  // wire bits as the master sees them at each link clock rise
  always @(posedge link.sclk)
  begin
    if (!setupMode)
    begin
      cap  = {cap[62:0], link.sdata};
      capN = capN + 1;
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (fail_count == 0 && n_compared > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // inverted six-bit checksum over position, error and warning
  function automatic logic [5:0] crcx(input logic [RES+1:0] v);
    logic [5:0] c;
    c = 6'h00;
    for (int i = RES + 1; i >= 0; i--)
    begin
      c = {c[4:0], 1'b0} ^ ((c[5] ^ v[i]) ? 6'h03 : 6'h00);
    end
    return ~c;
  endfunction

  task automatic wait_ready;
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 400)
    begin
      tick(1);
      k++;
    end
    check(64'({ready, busy, link.sdata}), 64'h5);
  endtask

  // one request: wire image, decoded results, refused early request
  task automatic frame(input logic biss, input logic [RES-1:0] ang, input logic flt);
    logic [63:0] exp;
    int          nb;
    int          k;
    // position must pass at least one refresh before the request
    angle    = ang;
    fault    = flt;
    tick(40);
    // mode changes only after the previous frame's length check
    bissMode = biss;
    nb       = biss ? RES + 11 : RES + 1;
    exp      = biss ? {33'h0, 3'h2, ang, ~flt, 1'b1, crcx({ang, ~flt, 1'b1})} : {43'h0, ang, flt};
    wait_ready;
    start = 1'b1;
    cap   = 64'h0;
    capN  = 0;
    tick(1);
    start = 1'b0;
    k     = 0;
    while (done !== 1'b1 && k < 600)
    begin
      tick(1);
      k++;
    end
    check(64'(done), 64'h1);
    check(64'(position), 64'(ang));
    check(64'({statusOk, warnBit, crcOk, frameOk}), {60'h0, ~flt, biss, 2'h3});
    check(64'(capN), 64'(nb + 1));
    check(cap & ((64'h1 << nb) - 64'h1), exp);
    check(64'(cap[nb]), 64'h1);
    tick(1);
    check(64'({done, busy}), 64'h1);
    start = 1'b1;
    tick(10);
    check(64'({ready, link.sclk}), 64'h1);
    start = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n      = 1'b0;
    bissMode   = 1'b1;
    setupMode  = 1'b0;
    sTx        = 1'b1;
    mTx        = 1'b1;
    angle      = 20'h00000;
    fault      = 1'b0;
    start      = 1'b0;
    cap        = 64'h0;
    capN       = 0;
    fail_count = 0;
    n_compared = 0;
    tab[0]     = 20'hFFFFF;
    tab[1]     = 20'h00000;
    tab[2]     = 20'h80001;
    tick(8);
    rst_n = 1'b1;
    frame(1'b1, 20'h5A3C1, 1'b0);
    // both protocols, boundary positions, both fault levels
    for (int m = 0; m < 2; m++)
    begin
      for (int i = 0; i < 3; i++)
      begin
        frame(m == 0, tab[i], i[0]);
      end
    end
    // service mode passes bits through the same wires
    tick(300);
    setupMode = 1'b1;
    mTx       = 1'b0;
    sTx       = 1'b0;
    tick(6);
    check(64'({ready, link.sclk, link.sdata, sRx, mRx}), 64'h00);
    mTx = 1'b1;
    sTx = 1'b1;
    tick(6);
    check(64'({ready, link.sclk, link.sdata, sRx, mRx}), 64'h0F);
    tick(30);
    setupMode = 1'b0;
    tick(300);
    // reset in mid-frame, then serve again without setup
    wait_ready;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(50);
    rst_n = 1'b0;
    tick(2);
    check(64'({link.sclk, link.sdata, busy, done, ready}), 64'h19);
    rst_n = 1'b1;
    frame(1'b1, 20'h12345, 1'b1);
    end_sim;
  end
endmodule
`default_nettype wire
